// ---- core/csp_clock_stop.sv ----
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
// How it works
// - Valid stop instruction turns the crystal oscillator off, device stops except the watchdog.
// - Stop acts only with chip enable low; otherwise it is a no-op.
// - Chip enable rising edge releases clock-stop through chip-enable reset.
// - Release pin rising edge wakes the device only if release enable is set.
// - Power-on reset also releases clock-stop.
// - Every release restarts the program at address zero.
// - Power-failure detector stays off while the clock is stopped.
// - Release by power-on reset switches the power-failure detector on.
// - Release pin rising edge is caught in a readable sticky flag.
// - Chip enable high after a no-op stop gives reset at timer 0 carry.
// - Halt pauses only instruction execution; peripherals keep running.
// - Clock-stop halts all peripherals except the watchdog.
// - Other timers stop in clock-stop; watchdog always runs.
// - Control registers hold through halt; valid stop pulses ctrlInit, release enable keeps its value.
// - Halt freezes the program counter; clock-stop clears it to zero.
// - Serial transfer continues in halt; its enabled interrupt ends halt.
// - Clock-stop aborts serial transfer and turns shared pins into inputs.
// - Chip enable pulses shorter than the filter window are ignored.
module csp_clock_stop #(
  parameter int CE_FILT_CYC = csp_pkg::CE_FILTER_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire csp_pkg::csp_bus_t bus,
  output logic [csp_pkg::DATA_W-1:0] regRdata,
  input wire logic chipEnable,
  input wire logic clockStopReleasePin,
  input wire logic powerOnReset,
  input wire logic stopExec,
  input wire logic [3:0] stopOperand,
  input wire logic haltActive,
  input wire logic timer0CarryFlag,
  input wire logic serial0RequestFlag,
  input wire logic serial0InterruptEnable,
  output csp_pkg::csp_ctl_t ctl
);
  import csp_pkg::*;

  csp_state_t state_q, state_d;
  logic [FILT_W-1:0] filtCnt_q, filtCnt_d;
  logic ceLevel_q, ceLevel_d;
  logic ceRise;
  logic relPrev_q;
  logic relRise;
  logic relEdge_q, relEdge_d;
  logic relEn_q, relEn_d;
  logic nopPending_q, nopPending_d;
  logic pfd_q, pfd_d;
  logic [SETTLE_W-1:0] settleCnt_q, settleCnt_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  csp_ctl_t ctl_q, ctl_d;
  logic stopValid;
  logic stopAsNop;
  logic ceReset;
  logic pinWake;
  logic wakeAny;
  logic settled;
  logic wrCtrl;
  logic wrStatus;
  logic edgeClear;

  function automatic logic regHit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
    regHit = (a == idx);
  endfunction

  // Chip enable filter: level follows the pin only after it is stable long enough
  // glitch filter window
  assign ceLevel_d = (filtCnt_q == FILT_W'(CE_FILT_CYC - 1)) ? chipEnable : ceLevel_q;
  assign filtCnt_d = (chipEnable == ceLevel_q && filtCnt_q != FILT_W'(CE_FILT_CYC - 1))
    ? '0 : ((filtCnt_q == FILT_W'(CE_FILT_CYC - 1)) ? '0 : filtCnt_q + FILT_W'(1));
  assign ceRise = (ceLevel_d && !ceLevel_q);

  assign relRise = clockStopReleasePin && !relPrev_q;

  // operand must be all zeros
  // Power-on reset in the same cycle wins, so the detector is never left on while stopped
  assign stopValid = stopExec && (stopOperand == STOP_OPERAND) && !ceLevel_q
    && (state_q == CSP_RUN) && !powerOnReset;
  // stop with chip enable high degrades to a no-op
  assign stopAsNop = stopExec && (stopOperand == STOP_OPERAND) && ceLevel_q
    && (state_q == CSP_RUN);

  // chip-enable reset from a rising edge, or from timer 0 carry
  assign ceReset = ceRise || (nopPending_q && ceLevel_q && timer0CarryFlag);
  // release pin wakes only when enabled
  assign pinWake = relRise && relEn_q;
  assign wakeAny = ceReset || pinWake || powerOnReset;
  assign settled = (settleCnt_q == SETTLE_W'(OSC_SETTLE_CYC - 1));

  // Register decode
  assign wrCtrl = bus.wr && regHit(bus.addr, REG_CTRL);
  assign wrStatus = bus.wr && regHit(bus.addr, REG_STATUS);
  assign edgeClear = wrStatus && bus.wdata[STAT_EDGE_BIT];

  // control register keeps value in halt and across a valid stop
  assign relEn_d = wrCtrl ? bus.wdata[CTRL_RLS_EN_BIT]
    : (stopValid ? relEn_q : relEn_q);

  // set wins over the software clear
  assign relEdge_d = relRise ? 1'b1 : (edgeClear ? 1'b0 : relEdge_q);

  assign nopPending_d = stopAsNop ? 1'b1
    : ((ceReset || !ceLevel_q) ? 1'b0 : nopPending_q);

  // detector off while stopped, on after power-on release
  assign pfd_d = powerOnReset ? 1'b1 : (stopValid ? 1'b0 : pfd_q);

  always_comb begin
    rdata_d = '0;
    if (bus.rd && regHit(bus.addr, REG_CTRL)) begin
      rdata_d[CTRL_RLS_EN_BIT] = relEn_q;
    end else if (bus.rd && regHit(bus.addr, REG_STATUS)) begin
      rdata_d[STAT_CE_LEVEL_BIT] = ceLevel_q;
      rdata_d[STAT_EDGE_BIT] = relEdge_q;
      rdata_d[STAT_PFD_BIT] = pfd_q;
      rdata_d[STAT_NOP_BIT] = nopPending_q;
    end
  end

  always_comb begin
    state_d = state_q;
    settleCnt_d = '0;
    case (state_q)
      CSP_RUN: begin
        if (stopValid) begin
          state_d = CSP_STOPPED;
        end else if (ceReset || powerOnReset) begin
          state_d = CSP_WAKE;
        end
      end
      CSP_STOPPED: begin
        if (wakeAny) begin
          state_d = CSP_WAKE;
        end
      end
      CSP_WAKE: begin
        if (settled) begin
          state_d = CSP_RUN;
        end else begin
          settleCnt_d = settleCnt_q + SETTLE_W'(1);
        end
      end
      default: begin
        state_d = CSP_RUN;
      end
    endcase
  end

  always_comb begin
    ctl_d = '0;
    ctl_d.oscEnable = (state_d != CSP_STOPPED);
    // program restarts from address zero after reset
    ctl_d.cpuReset = (state_d == CSP_WAKE);
    // pc cleared in clock-stop, frozen in halt
    ctl_d.pcZero = (state_d != CSP_RUN);
    ctl_d.pcHold = (state_d == CSP_RUN) && haltActive;
    // peripherals run in halt, stop in clock-stop
    ctl_d.periphRun = (state_d == CSP_RUN);
    ctl_d.watchdogRun = 1'b1;
    // reinitialise control registers on a valid stop
    ctl_d.ctrlInit = stopValid;
    ctl_d.serialAbort = stopValid;
    ctl_d.pinsToInput = (state_d == CSP_STOPPED);
    ctl_d.pfdEnable = pfd_d;
    ctl_d.haltWake = (state_d == CSP_RUN) && haltActive
      && serial0RequestFlag && serial0InterruptEnable;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= CSP_RUN;
      filtCnt_q <= '0;
      ceLevel_q <= 1'b0;
      relPrev_q <= 1'b0;
      relEdge_q <= 1'b0;
      relEn_q <= CTRL_RESET[CTRL_RLS_EN_BIT];
      nopPending_q <= 1'b0;
      pfd_q <= 1'b1;
      settleCnt_q <= '0;
      rdata_q <= '0;
      ctl_q <= '0;
    end else if (clkEn) begin
      state_q <= state_d;
      filtCnt_q <= filtCnt_d;
      ceLevel_q <= ceLevel_d;
      relPrev_q <= clockStopReleasePin;
      relEdge_q <= relEdge_d;
      relEn_q <= relEn_d;
      nopPending_q <= nopPending_d;
      pfd_q <= pfd_d;
      settleCnt_q <= settleCnt_d;
      rdata_q <= rdata_d;
      ctl_q <= ctl_d;
    end
  end

  assign regRdata = rdata_q;
  assign ctl = ctl_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_validStop;
    clkEn && stopValid;
  endsequence

  sequence s_stoppedOut;
    !ctl.oscEnable && ctl.pinsToInput && !ctl.periphRun && ctl.pcZero;
  endsequence

  chk_stop_halts_osc: assert property (s_validStop |=> s_stoppedOut)
    else $error("valid stop did not stop oscillator");

  chk_nop_when_ce_high: assert property (
    clkEn && stopAsNop |=> ctl.oscEnable && nopPending_q)
    else $error("stop with chip enable high was not a no-op");

  chk_ce_rise_wakes: assert property (
    clkEn && state_q == CSP_STOPPED && ceRise |=> state_q == CSP_WAKE)
    else $error("chip enable rise did not wake");

  chk_pin_needs_en: assert property (
    clkEn && state_q == CSP_STOPPED && relRise && !relEn_q && !ceReset && !powerOnReset
    |=> state_q == CSP_STOPPED)
    else $error("release pin woke without enable");

  chk_por_pfd_on: assert property (
    clkEn && powerOnReset |=> ctl.pfdEnable && pfd_q)
    else $error("power-on release left detector off");

  chk_pfd_off_stopped: assert property (
    state_q == CSP_STOPPED |-> !pfd_q)
    else $error("detector active while stopped");

  chk_edge_flag_sticky: assert property (
    clkEn && relRise |=> relEdge_q)
    else $error("release pin edge not recorded");

  chk_carry_reset: assert property (
    clkEn && state_q == CSP_RUN && nopPending_q && ceLevel_q && timer0CarryFlag
    |=> state_q == CSP_WAKE ##1 ctl.cpuReset)
    else $error("timer carry did not apply reset");

  chk_wake_hold_reset: assert property (
    clkEn && state_q == CSP_STOPPED && wakeAny |=> ##1 ctl.cpuReset && ctl.pcZero)
    else $error("reset not held after wake");

  chk_watchdog_runs: assert property (
    $rose(state_q == CSP_STOPPED) |-> ##1 ctl.watchdogRun)
    else $error("watchdog stopped");

  chk_halt_periph_run: assert property (
    clkEn && state_q == CSP_RUN && haltActive && !stopValid && !ceReset && !powerOnReset
    |=> ctl.periphRun && ctl.pcHold)
    else $error("halt disturbed peripherals");

  chk_filter_glitch: assert property (
    clkEn && !ceLevel_q && filtCnt_q == '0 && chipEnable ##1 clkEn && !chipEnable
    |=> !ceLevel_q)
    else $error("short chip enable pulse changed level");

  sequence s_resetHeld;
    (ctl.cpuReset && ctl.pcZero && ctl.oscEnable) [*8];
  endsequence

  chk_init_on_stop: assert property (s_validStop |=> ctl.ctrlInit)
    else $error("valid stop did not reinitialise control registers");

  chk_serial_abort: assert property (s_validStop |=> ctl.serialAbort && ctl.pinsToInput)
    else $error("valid stop did not abort serial transfer");

  chk_pfd_off_stop: assert property (s_validStop |=> !ctl.pfdEnable)
    else $error("detector left on after valid stop");

  chk_wake_pc_zero: assert property (state_q == CSP_WAKE |-> ctl.cpuReset && ctl.pcZero)
    else $error("wake without reset to address zero");

  chk_stopped_periph_off: assert property (
    state_q == CSP_STOPPED |-> !ctl.periphRun && !ctl.oscEnable)
    else $error("peripherals running while stopped");

  chk_watchdog_stopped: assert property (state_q == CSP_STOPPED |-> ctl.watchdogRun)
    else $error("watchdog halted in clock-stop");

  chk_pin_wakes: assert property (
    clkEn && state_q == CSP_STOPPED && relRise && relEn_q |=> state_q == CSP_WAKE)
    else $error("enabled release pin did not wake");

  chk_por_wakes: assert property (
    clkEn && state_q == CSP_STOPPED && powerOnReset |=> state_q == CSP_WAKE)
    else $error("power-on reset did not wake");

  chk_settle_hold: assert property (
    clkEn && state_q == CSP_STOPPED && wakeAny |=> s_resetHeld)
    else $error("reset released before oscillator settled");

  chk_edge_set_wins: assert property (clkEn && relRise && edgeClear |=> relEdge_q)
    else $error("clear beat a new release pin edge");

  chk_edge_cleared: assert property (clkEn && edgeClear && !relRise |=> !relEdge_q)
    else $error("edge flag not cleared by software");

  chk_halt_wake: assert property (
    clkEn && state_q == CSP_RUN && haltActive && serial0RequestFlag && serial0InterruptEnable
    && !stopValid && !ceReset && !powerOnReset |=> ctl.haltWake)
    else $error("enabled serial interrupt did not end halt");

  chk_stop_refused: assert property (
    clkEn && stopExec && state_q == CSP_STOPPED && !wakeAny |=> state_q == CSP_STOPPED)
    else $error("stop instruction acted outside run");

  chk_pc_zero_stop: assert property (
    state_q == CSP_STOPPED |-> ctl.pcZero && !ctl.pcHold)
    else $error("program counter not cleared in clock-stop");

  chk_nop_cleared: assert property (
    clkEn && ceReset && !stopAsNop |=> !nopPending_q)
    else $error("no-op pending survived chip-enable reset");

  chk_ce_level_hold: assert property (
    clkEn && chipEnable == ceLevel_q |=> ceLevel_q == $past(ceLevel_q))
    else $error("filtered level moved while pin agreed");

  chk_clken_freeze: assert property (!clkEn |=> $stable(state_q) && $stable(ctl))
    else $error("state moved with clock enable low");

  chk_rd_idle_zero: assert property (clkEn && !bus.rd |=> regRdata == '0)
    else $error("read data not zero outside read");

endmodule

// ---- common/csp_pkg.sv ----
package csp_pkg;

  // Register bus widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 4;

  // Register indices
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;

  // Control register fields
  localparam int CTRL_RLS_EN_BIT = 0;
  localparam logic [DATA_W-1:0] CTRL_RESET = 4'h0;

  // Status register fields
  localparam int STAT_CE_LEVEL_BIT = 0;
  localparam int STAT_EDGE_BIT = 1;
  localparam int STAT_PFD_BIT = 2;
  localparam int STAT_NOP_BIT = 3;

  // Stop instruction operand that is accepted
  localparam logic [3:0] STOP_OPERAND = 4'h0;

  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CE_FILTER_MIN_NS = 110;
  localparam int CE_FILTER_MIN_US = 110;
  localparam int CE_FILTER_CYC = (CE_FILTER_MIN_US * 1000 * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam int OSC_SETTLE_NS = 100;
  localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FILT_W = 16;
  localparam int SETTLE_W = 8;

  // Power state, one bit changes on run -> stopped and stopped -> wake
  typedef enum logic [1:0] {
    CSP_RUN = 2'b00,
    CSP_STOPPED = 2'b01,
    CSP_WAKE = 2'b11
  } csp_state_t;

  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } csp_bus_t;

  // Outputs toward the rest of the chip
  typedef struct packed {
    logic oscEnable;
    logic cpuReset;
    logic pcZero;
    logic pcHold;
    logic periphRun;
    logic watchdogRun;
    logic ctrlInit;
    logic serialAbort;
    logic pinsToInput;
    logic pfdEnable;
    logic haltWake;
  } csp_ctl_t;

endpackage

// ---- verification/csp_sys_ctrl_model.sv ----
`timescale 1ns/1ps
// External system controller driving chip enable and the release pin
module csp_sys_ctrl_model (
  input wire logic clk,
  input wire logic ceReq,
  input wire logic releaseReq,
  input wire logic glitchReq,
  output logic chipEnable,
  output logic clockStopReleasePin
);
  logic [3:0] glitchCnt;
  initial begin
    chipEnable = 1'b0;
    clockStopReleasePin = 1'b0;
    glitchCnt = 4'h0;
  end
  // short inverted pulse on chip enable, three cycles wide
  always @(posedge clk) begin
    if (glitchReq) begin
      glitchCnt <= 4'h3;
    end else if (glitchCnt != 4'h0) begin
      glitchCnt <= glitchCnt - 4'h1;
    end
    chipEnable <= ceReq ^ (glitchReq || glitchCnt > 4'h1);
    clockStopReleasePin <= releaseReq;
  end
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import csp_pkg::*;
  logic clk = 1'b0, rst = 1'b1, clkEn = 1'b1, powerOnReset = 1'b0, stopExec = 1'b0;
  logic haltActive = 1'b0, timer0CarryFlag = 1'b0, serReq = 1'b0, serEn = 1'b0;
  logic ceReq = 1'b0, relReq = 1'b0, glitchReq = 1'b0, chipEnable, relPin;
  logic [3:0] stopOperand = 4'h0, regRdata, rdat;
  csp_bus_t bus = '0;
  csp_ctl_t ctl;
  int miscompares = 0, num_checks = 0;
  csp_clock_stop #(.CE_FILT_CYC(8)) u_csp_clock_stop (.clk(clk), .rst(rst), .clkEn(clkEn),
    .bus(bus), .regRdata(regRdata), .chipEnable(chipEnable), .clockStopReleasePin(relPin),
    .powerOnReset(powerOnReset), .stopExec(stopExec), .stopOperand(stopOperand),
    .haltActive(haltActive), .timer0CarryFlag(timer0CarryFlag),
    .serial0RequestFlag(serReq), .serial0InterruptEnable(serEn), .ctl(ctl));
  csp_sys_ctrl_model u_csp_sys_ctrl_model (.clk(clk), .ceReq(ceReq), .releaseReq(relReq),
    .glitchReq(glitchReq), .chipEnable(chipEnable), .clockStopReleasePin(relPin));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 rdat = regRdata;
  endtask
  task automatic stopCmd(input logic [3:0] op);
    @(posedge clk);
    stopExec <= 1'b1;
    stopOperand <= op;
    @(posedge clk);
    stopExec <= 1'b0;
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = ctl.oscEnable;
      1: pick = ctl.cpuReset;
      default: pick = ctl.haltWake;
    endcase
  endfunction
  task automatic waitChk(input int sel, input logic val, input int lim);
    #1;
    for (int i = 0; i < lim && pick(sel) !== val; i++) begin
      @(posedge clk);
      #1;
    end
    chk({3'h0, pick(sel)}, {3'h0, val});
  endtask
  task automatic wake();
    waitChk(1, 1'b1, 24);
    chk({2'h0, ctl.pcZero, ctl.oscEnable}, 4'h3);
    waitChk(1, 1'b0, 30);
    chk({2'h0, ctl.cpuReset, ctl.periphRun}, 4'h1);
  endtask
  task automatic testReset();
    rd(REG_CTRL);
    chk(rdat, CTRL_RESET);
    rd(REG_STATUS);
    chk(rdat, 4'h4);
    chk({2'h0, ctl.oscEnable, ctl.watchdogRun}, 4'h3);
    $display("test reset done");
  endtask
  task automatic testPinRelease();
    wr(REG_CTRL, 4'h1);
    stopCmd(STOP_OPERAND);
    #1 chk({2'h0, ctl.ctrlInit, ctl.serialAbort}, 4'h3);
    waitChk(0, 1'b0, 4);
    chk({ctl.periphRun, ctl.watchdogRun, ctl.pcZero, ctl.pinsToInput}, 4'h7);
    @(posedge clk);
    #1 chk({2'h0, ctl.ctrlInit, ctl.serialAbort}, 4'h0);
    chk({3'h0, ctl.pfdEnable}, 4'h0);
    @(posedge clk);
    relReq <= 1'b1;
    wake();
    rd(REG_STATUS);
    chk(rdat & 4'h2, 4'h2);
    wr(REG_STATUS, 4'h2);
    rd(REG_STATUS);
    chk(rdat & 4'h2, 4'h0);
    @(posedge clk);
    relReq <= 1'b0;
    $display("test release pin done");
  endtask
  task automatic testCeRelease();
    wr(REG_CTRL, 4'h0);
    stopCmd(STOP_OPERAND);
    waitChk(0, 1'b0, 4);
    @(posedge clk);
    relReq <= 1'b1;
    glitchReq <= 1'b1;
    @(posedge clk);
    glitchReq <= 1'b0;
    repeat (15) @(posedge clk);
    #1 chk({2'h0, ctl.oscEnable, ctl.cpuReset}, 4'h0);
    @(posedge clk);
    ceReq <= 1'b1;
    relReq <= 1'b0;
    wake();
    rd(REG_STATUS);
    chk(rdat & 4'h1, 4'h1);
    $display("test chip enable release done");
  endtask
  task automatic testNop();
    stopCmd(STOP_OPERAND);
    repeat (3) @(posedge clk);
    #1 chk({3'h0, ctl.oscEnable}, 4'h1);
    rd(REG_STATUS);
    chk(rdat & 4'h8, 4'h8);
    @(posedge clk);
    timer0CarryFlag <= 1'b1;
    @(posedge clk);
    timer0CarryFlag <= 1'b0;
    wake();
    @(posedge clk);
    ceReq <= 1'b0;
    repeat (14) @(posedge clk);
    stopCmd(4'h5);
    repeat (3) @(posedge clk);
    #1 chk({3'h0, ctl.oscEnable}, 4'h1);
    $display("test no-op stop done");
  endtask
  task automatic testPor();
    stopCmd(STOP_OPERAND);
    waitChk(0, 1'b0, 4);
    @(posedge clk);
    powerOnReset <= 1'b1;
    @(posedge clk);
    powerOnReset <= 1'b0;
    wake();
    chk({3'h0, ctl.pfdEnable}, 4'h1);
    $display("test power-on release done");
  endtask
  task automatic testHalt();
    @(posedge clk);
    clkEn <= 1'b0;
    stopExec <= 1'b1;
    repeat (3) @(posedge clk);
    stopExec <= 1'b0;
    clkEn <= 1'b1;
    #1 chk({3'h0, ctl.oscEnable}, 4'h1);
    @(posedge clk);
    haltActive <= 1'b1;
    serReq <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({1'h0, ctl.pcHold, ctl.haltWake, ctl.periphRun}, 4'h5);
    @(posedge clk);
    serEn <= 1'b1;
    waitChk(2, 1'b1, 4);
    @(posedge clk);
    haltActive <= 1'b0;
    $display("test halt done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    testReset();
    testPinRelease();
    testCeRelease();
    testNop();
    testPor();
    testHalt();
    summarize();
  end
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    summarize();
  end
endmodule
